// file: hdl/ppb_bridge.sv
// Controller side of the PCI pass-thru to host port bridge
//
// Function
// - Two 32-bit, 8-word queues with pointer, count
// - Queue flag pins, status copies, direct strobes
// - Eight 32-bit mailboxes, four each way, flags
// - 64-byte configuration space, PCI side only
// - Sixteen PCI-side operation registers, host only
// - Fourteen add-on registers, pass-thru address, data
// - Four pass-thru regions with own widths
// - Address register, two data registers, status pins
// - Single and burst pass-thru transfers
// - Definition bits 31:30 = 10 mean 16-bit
// - Width pin high selects 16-bit pass-thru data
// - Lane enables steer halves onto low bits
// - Indicators raised on access; glue moves data
// - Host port has control, address, data registers
`include "ppb_regs.svh"
module ppb_bridge (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                pci_req,
  input  wire logic                pci_write,
  input  wire ppb_pkg::ppb_space_t pci_space,
  input  wire logic [31:0]         pci_addr,
  input  wire logic [31:0]         pci_wdata,
  input  wire logic [3:0]          pci_lanes_n,
  input  wire logic                pci_burst,
  input  wire logic [1:0]          pci_region,
  output logic                     pci_ack,
  output logic      [31:0]         pci_rdata,
  input  wire logic                width_select,
  input  wire logic                addon_select_n,
  input  wire logic                addon_rd_n,
  input  wire logic                addon_wr_n,
  input  wire logic [4:0]          addon_adr,
  input  wire logic [3:0]          lane_select_n,
  input  wire logic [31:0]         addon_data_in,
  output logic      [31:0]         addon_data_out,
  output logic                     addon_data_oe,
  input  wire logic                passthru_addr_en_n,
  input  wire logic                read_queue_strobe_n,
  input  wire logic                write_queue_strobe_n,
  input  wire logic                passthru_done_n,
  output logic                     passthru_attn_n,
  output logic                     passthru_burst_n,
  output logic      [1:0]          passthru_region,
  output logic      [3:0]          passthru_lanes_n,
  output logic                     passthru_write,
  output logic                     read_queue_empty,
  output logic                     write_queue_full,
  output logic                     pci_mail_event,
  output logic                     addon_mail_event,
  output logic                     buffered_bus_reset_n
);
  import ppb_pkg::*;

  typedef struct packed {
    ppb_state_t       state;
    logic             ack;
    logic [31:0]      rdata;
    logic [3:0][31:0] mb_in;
    logic [3:0][31:0] mb_out;
    logic [3:0]       mb_in_full;
    logic [3:0]       mb_out_full;
    logic [31:0]      qin_ptr;
    logic [31:0]      qin_cnt;
    logic [31:0]      qout_ptr;
    logic [31:0]      qout_cnt;
    logic [31:0]      nv_word;
    logic [31:0]      ctrl;
    logic [3:0]       region16;
    logic [31:0]      pt_addr;
    logic [31:0]      pt_wdata;
    logic [31:0]      pt_rdata;
    logic             pt_write;
    logic             pt_burst_n;
    logic [1:0]       pt_region;
    logic [3:0]       pt_lanes_n;
    logic             attn_n;
    logic [31:0]      ad_out;
    logic             ad_oe;
    logic             rd_prev;
    logic             wr_prev;
    logic             rq_prev;
    logic             wq_prev;
    logic             done_prev;
    logic             rq_empty;
    logic             wq_full;
    logic             pci_mail;
    logic             addon_mail;
    logic             rst_out_n;
  } ppb_st_t;

  ppb_st_t     r;
  ppb_st_t     next_r;
  logic        cfg_we;
  logic [3:0]  cfg_raddr;
  logic [31:0] cfg_rdata;
  logic        qin_push;
  logic        qin_pop;
  logic        qout_push;
  logic        qout_pop;
  logic [31:0] qout_wdata;

  ppb_stream_if #(.W(`PPB_Q_WIDTH)) qin_wr ();
  ppb_stream_if #(.W(`PPB_Q_WIDTH)) qin_rd ();
  ppb_stream_if #(.W(`PPB_Q_WIDTH)) qout_wr ();
  ppb_stream_if #(.W(`PPB_Q_WIDTH)) qout_rd ();

  assign qin_wr.valid = qin_push;
  assign qin_wr.data = pci_wdata;
  assign qin_rd.ready = qin_pop;
  assign qout_wr.valid = qout_push;
  assign qout_wr.data = qout_wdata;
  assign qout_rd.ready = qout_pop;

  ppb_fifo #(.WIDTH(`PPB_Q_WIDTH), .DEPTH(`PPB_Q_DEPTH)) u_qin (
    .clk    (clk),
    .resetn (resetn),
    .flush  (r.ctrl[`PPB_CTRL_FLUSH]),
    .in_s   (qin_wr),
    .out_s  (qin_rd)
  );

  ppb_fifo #(.WIDTH(`PPB_Q_WIDTH), .DEPTH(`PPB_Q_DEPTH)) u_qout (
    .clk    (clk),
    .resetn (resetn),
    .flush  (r.ctrl[`PPB_CTRL_FLUSH]),
    .in_s   (qout_wr),
    .out_s  (qout_rd)
  );

  ppb_mem u_cfg (
    .clk    (clk),
    .resetn (resetn),
    .we     (cfg_we),
    .waddr  (pci_addr[5:2]),
    .wdata  (pci_wdata),
    .raddr  (cfg_raddr),
    .rdata  (cfg_rdata)
  );

  assign pci_ack = r.ack;
  assign pci_rdata = r.rdata;
  assign addon_data_out = r.ad_out;
  assign addon_data_oe = r.ad_oe;
  assign passthru_attn_n = r.attn_n;
  assign passthru_burst_n = r.pt_burst_n;
  assign passthru_region = r.pt_region;
  assign passthru_lanes_n = r.pt_lanes_n;
  assign passthru_write = r.pt_write;
  assign read_queue_empty = r.rq_empty;
  assign write_queue_full = r.wq_full;
  assign pci_mail_event = r.pci_mail;
  assign addon_mail_event = r.addon_mail;
  assign buffered_bus_reset_n = r.rst_out_n;

  // Byte-lane merge for add-on writes; narrow bus copies low half up
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] din,
    input logic [3:0]  lanes_n,
    input logic        narrow
  );
    logic [31:0] src;
    logic [31:0] res;
    src = narrow ? {din[15:0], din[15:0]} : din;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (!lanes_n[b]) begin
        res[8*b +: 8] = src[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Narrow reads put the selected half on the low 16 bits
  function automatic logic [31:0] lane_read(
    input logic [31:0] word,
    input logic [3:0]  lanes_n,
    input logic        narrow
  );
    logic [31:0] res;
    res = word;
    if (narrow) begin
      res = (lanes_n[1:0] == 2'b11) ? {16'h0000, word[31:16]}
                                    : {16'h0000, word[15:0]};
    end
    return res;
  endfunction

  always_comb begin
    logic        ad_rd;
    logic        ad_wr;
    logic        rd_fire;
    logic        wr_fire;
    logic        rq_fire;
    logic        wq_fire;
    logic        done_fire;
    logic        narrow;
    logic [3:0]  idx;
    logic [31:0] stat;
    logic [31:0] ad_word;
    next_r = r;
    cfg_we = 1'b0;
    cfg_raddr = pci_addr[5:2];
    qin_push = 1'b0;
    qin_pop = 1'b0;
    qout_push = 1'b0;
    qout_pop = 1'b0;
    qout_wdata = addon_data_in;
    idx = pci_addr[5:2];
    stat = '0;
    ad_word = '0;
    ad_rd = !addon_select_n && !addon_rd_n;
    ad_wr = !addon_select_n && !addon_wr_n;
    rd_fire = ad_rd && !r.rd_prev;
    wr_fire = ad_wr && !r.wr_prev;
    rq_fire = !read_queue_strobe_n && !r.rq_prev;
    wq_fire = !write_queue_strobe_n && !r.wq_prev;
    done_fire = !passthru_done_n && r.done_prev;
    narrow = width_select || r.region16[r.pt_region];
    next_r.rd_prev = ad_rd;
    next_r.wr_prev = ad_wr;
    next_r.rq_prev = !read_queue_strobe_n;
    next_r.wq_prev = !write_queue_strobe_n;
    next_r.done_prev = passthru_done_n;
    next_r.ack = 1'b0;
    next_r.rst_out_n = 1'b1;

    stat[`PPB_ST_MBI +: 4] = r.mb_in_full;
    stat[`PPB_ST_MBO +: 4] = r.mb_out_full;
    stat[`PPB_ST_QIN_MT] = !qin_rd.valid;
    stat[`PPB_ST_QOUT_FL] = !qout_wr.ready;
    stat[`PPB_ST_QIN_FL] = !qin_wr.ready;
    stat[`PPB_ST_QOUT_MT] = !qout_rd.valid;
    stat[`PPB_ST_ATTN] = !r.attn_n;

    case (r.state)
      PPB_S_IDLE: begin
        if (pci_req) begin
          case (pci_space)
            PPB_SP_CFG: begin
              if (pci_write) begin
                cfg_we = 1'b1;
                if (idx[3:2] == `PPB_CFG_BAR0 >> 2) begin
                  next_r.region16[idx[1:0]] =
                    (pci_wdata[`PPB_BAR_WHI:`PPB_BAR_WLO] == `PPB_BAR_W16);
                end
                next_r.ack = 1'b1;
                next_r.state = PPB_S_ACK;
              end else begin
                next_r.state = PPB_S_CFG_RD;
              end
            end
            PPB_SP_OP: begin
              next_r.ack = 1'b1;
              next_r.state = PPB_S_ACK;
              next_r.rdata = '0;
              if (pci_write) begin
                case (idx)
                  `PPB_OP_QDATA: begin
                    // Full queue holds the PCI cycle off, not drops it
                    qin_push = 1'b1;
                    if (qin_wr.ready) begin
                      next_r.qin_ptr = r.qin_ptr + `PPB_PTR_STEP;
                      if (r.qin_cnt != '0) begin
                        next_r.qin_cnt = r.qin_cnt - 32'h1;
                      end
                    end else begin
                      next_r.ack = 1'b0;
                      next_r.state = PPB_S_IDLE;
                    end
                  end
                  `PPB_OP_QIN_PTR: next_r.qin_ptr = pci_wdata;
                  `PPB_OP_QIN_CNT: next_r.qin_cnt = pci_wdata;
                  `PPB_OP_QOUT_PTR: next_r.qout_ptr = pci_wdata;
                  `PPB_OP_QOUT_CNT: next_r.qout_cnt = pci_wdata;
                  `PPB_OP_NV: next_r.nv_word = pci_wdata;
                  `PPB_OP_CTRL: next_r.ctrl = pci_wdata;
                  default: begin
                    if (idx[3:2] == `PPB_OP_MBI0 >> 2) begin
                      next_r.mb_in[idx[1:0]] = pci_wdata;
                    end
                  end
                endcase
              end else begin
                case (idx)
                  `PPB_OP_QDATA: begin
                    // Empty queue reads as zero
                    qout_pop = qout_rd.valid;
                    next_r.rdata = qout_rd.valid ? qout_rd.data : '0;
                  end
                  `PPB_OP_QIN_PTR: next_r.rdata = r.qin_ptr;
                  `PPB_OP_QIN_CNT: next_r.rdata = r.qin_cnt;
                  `PPB_OP_QOUT_PTR: next_r.rdata = r.qout_ptr;
                  `PPB_OP_QOUT_CNT: next_r.rdata = r.qout_cnt;
                  `PPB_OP_STATUS: next_r.rdata = stat;
                  `PPB_OP_NV: next_r.rdata = r.nv_word;
                  `PPB_OP_CTRL: next_r.rdata = r.ctrl;
                  default: begin
                    if (idx[3:2] == `PPB_OP_MBI0 >> 2) begin
                      next_r.rdata = r.mb_in[idx[1:0]];
                    end else begin
                      next_r.rdata = r.mb_out[idx[1:0]];
                      next_r.mb_out_full[idx[1:0]] = 1'b0;
                    end
                  end
                endcase
              end
            end
            PPB_SP_PT: begin
              next_r.pt_addr = pci_addr;
              next_r.pt_wdata = pci_wdata;
              next_r.pt_write = pci_write;
              next_r.pt_lanes_n = pci_lanes_n;
              next_r.pt_region = pci_region;
              next_r.pt_burst_n = !pci_burst;
              next_r.attn_n = 1'b0;
              next_r.state = PPB_S_PT_WAIT;
            end
            default: begin
              next_r.ack = 1'b1;
              next_r.rdata = '0;
              next_r.state = PPB_S_ACK;
            end
          endcase
        end
      end
      PPB_S_CFG_RD: begin
        next_r.rdata = cfg_rdata;
        next_r.ack = 1'b1;
        next_r.state = PPB_S_ACK;
      end
      PPB_S_PT_WAIT: begin
        if (done_fire) begin
          next_r.rdata = r.pt_rdata;
          next_r.attn_n = 1'b1;
          next_r.pt_burst_n = 1'b1;
          next_r.ack = 1'b1;
          next_r.state = PPB_S_ACK;
        end
      end
      PPB_S_ACK: begin
        next_r.state = PPB_S_IDLE;
      end
      default: begin
        next_r.state = PPB_S_IDLE;
      end
    endcase

    case (addon_adr)
      `PPB_AO_QDATA: ad_word = qin_rd.valid ? qin_rd.data : '0;
      `PPB_AO_STATUS: ad_word = stat;
      `PPB_AO_PTADDR: ad_word = r.pt_addr;
      `PPB_AO_PTDATA: ad_word = lane_read(r.pt_wdata, lane_select_n, narrow);
      `PPB_AO_NV: ad_word = r.nv_word;
      `PPB_AO_CTRL: ad_word = r.ctrl;
      default: begin
        if (addon_adr[4:2] == `PPB_AO_MBI0 >> 2) begin
          ad_word = r.mb_in[addon_adr[1:0]];
        end else if (addon_adr[4:2] == `PPB_AO_MBO0 >> 2) begin
          ad_word = r.mb_out[addon_adr[1:0]];
        end
      end
    endcase
    if (rd_fire) begin
      next_r.ad_out = ad_word;
      if (addon_adr[4:2] == `PPB_AO_MBI0 >> 2) begin
        next_r.mb_in_full[addon_adr[1:0]] = 1'b0;
      end
      if (addon_adr == `PPB_AO_QDATA) begin
        qin_pop = qin_rd.valid;
      end
    end
    if (!passthru_addr_en_n) begin
      next_r.ad_out = r.pt_addr;
    end
    if (rq_fire) begin
      next_r.ad_out = qin_rd.valid ? qin_rd.data : '0;
      qin_pop = qin_rd.valid;
    end
    next_r.ad_oe = ad_rd || !passthru_addr_en_n || !read_queue_strobe_n;

    if (wr_fire) begin
      case (addon_adr)
        `PPB_AO_QDATA: qout_push = 1'b1;
        `PPB_AO_PTDATA: next_r.pt_rdata =
          lane_merge(r.pt_rdata, addon_data_in, lane_select_n, narrow);
        `PPB_AO_NV: next_r.nv_word = addon_data_in;
        `PPB_AO_CTRL: next_r.ctrl = addon_data_in;
        default: begin
          if (addon_adr[4:2] == `PPB_AO_MBO0 >> 2) begin
            next_r.mb_out[addon_adr[1:0]] = addon_data_in;
          end
        end
      endcase
    end
    // write strobe push; full queue drops word
    if (wq_fire) begin
      qout_push = 1'b1;
    end
    if (qout_push && qout_wr.ready) begin
      next_r.qout_ptr = r.qout_ptr + `PPB_PTR_STEP;
      if (r.qout_cnt != '0) begin
        next_r.qout_cnt = r.qout_cnt - 32'h1;
      end
    end

    // set after clear, so a new word is never lost
    if (r.state == PPB_S_IDLE && pci_req && pci_write &&
        pci_space == PPB_SP_OP && idx[3:2] == `PPB_OP_MBI0 >> 2) begin
      next_r.mb_in_full[idx[1:0]] = 1'b1;
    end
    if (wr_fire && addon_adr[4:2] == `PPB_AO_MBO0 >> 2) begin
      next_r.mb_out_full[addon_adr[1:0]] = 1'b1;
    end
    next_r.pci_mail = |next_r.mb_out_full;
    next_r.addon_mail = |next_r.mb_in_full;
    // flag pins, one cycle behind the queues
    next_r.rq_empty = !qin_rd.valid;
    next_r.wq_full = !qout_wr.ready;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.state <= PPB_S_IDLE;
      r.ctrl <= `PPB_CTRL_RST;
      r.attn_n <= 1'b1;
      r.pt_burst_n <= 1'b1;
      r.pt_lanes_n <= 4'hf;
      r.rd_prev <= 1'b1;
      r.wr_prev <= 1'b1;
      r.rq_prev <= 1'b1;
      r.wq_prev <= 1'b1;
      r.done_prev <= 1'b1;
      r.rq_empty <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
endmodule // ppb_bridge

// file: common/ppb_regs.svh
// Offsets, field positions, reset values and widths of the pass-thru bridge
`ifndef PPB_REGS_SVH
`define PPB_REGS_SVH

// Configuration space: 16 words, region definitions at words 4 to 7
`define PPB_CFG_WORDS   16
`define PPB_CFG_BAR0    4'h4
`define PPB_BAR_WHI     31
`define PPB_BAR_WLO     30
`define PPB_BAR_W16     2'b10

// PCI-side operation registers, word index from pci_addr[5:2]
`define PPB_OP_MBI0     4'h0
`define PPB_OP_MBO0     4'h4
`define PPB_OP_QDATA    4'h8
`define PPB_OP_QIN_PTR  4'h9
`define PPB_OP_QIN_CNT  4'ha
`define PPB_OP_QOUT_PTR 4'hb
`define PPB_OP_QOUT_CNT 4'hc
`define PPB_OP_STATUS   4'hd
`define PPB_OP_NV       4'he
`define PPB_OP_CTRL     4'hf

// Add-on operation registers, word index from addon_adr
`define PPB_AO_MBO0     5'h00
`define PPB_AO_MBI0     5'h04
`define PPB_AO_QDATA    5'h08
`define PPB_AO_STATUS   5'h09
`define PPB_AO_PTADDR   5'h0a
`define PPB_AO_PTDATA   5'h0b
`define PPB_AO_NV       5'h0c
`define PPB_AO_CTRL     5'h0d

// Status word fields
`define PPB_ST_MBI      0
`define PPB_ST_MBO      4
`define PPB_ST_QIN_MT   8
`define PPB_ST_QOUT_FL  9
`define PPB_ST_QIN_FL   10
`define PPB_ST_QOUT_MT  11
`define PPB_ST_ATTN     12

// Control word fields and reset value
`define PPB_CTRL_FLUSH  0
`define PPB_CTRL_RST    32'h0000_0000

// Queue geometry and pointer step
`define PPB_Q_WIDTH     32
`define PPB_Q_DEPTH     8
`define PPB_PTR_STEP    32'h0000_0004

`endif

// file: common/ppb_pkg.sv
// Types shared by the pass-thru bridge modules
package ppb_pkg;
  typedef enum logic [1:0] {
    PPB_SP_CFG,
    PPB_SP_OP,
    PPB_SP_PT
  } ppb_space_t;

  typedef enum logic [1:0] {
    PPB_S_IDLE,
    PPB_S_CFG_RD,
    PPB_S_PT_WAIT,
    PPB_S_ACK
  } ppb_state_t;
endpackage

// file: common/ppb_stream_if.sv
// Valid/ready word stream between bridge modules
interface ppb_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: hdl/ppb_fifo.sv
// Parameterised queue with valid/ready on both sides
module ppb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic flush,
  ppb_stream_if.snk in_s,
  ppb_stream_if.src out_s
);
  import ppb_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } ppb_fifo_st_t;

  ppb_fifo_st_t r;
  ppb_fifo_st_t next_r;
  logic         push;
  logic         pop;

  assign in_s.ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = (r.cnt != '0);
  assign out_s.data = r.mem[r.rp];

  always_comb begin
    next_r = r;
    push = in_s.valid && in_s.ready;
    pop = out_s.valid && out_s.ready;
    if (push) begin
      next_r.mem[r.wp] = in_s.data;
      next_r.wp = AW'(r.wp + 1'b1);
    end
    if (pop) begin
      next_r.rp = AW'(r.rp + 1'b1);
    end
    if (push && !pop) begin
      next_r.cnt = (AW+1)'(r.cnt + 1'b1);
    end else if (pop && !push) begin
      next_r.cnt = (AW+1)'(r.cnt - 1'b1);
    end
    // Flush drops contents but keeps storage, cheaper than clearing it
    if (flush) begin
      next_r.wp = '0;
      next_r.rp = '0;
      next_r.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // ppb_fifo

// file: hdl/ppb_mem.sv
// Configuration space store with registered read data
`include "ppb_regs.svh"
module ppb_mem (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        we,
  input  wire logic [3:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  raddr,
  output logic      [31:0] rdata
);
  import ppb_pkg::*;

  typedef struct packed {
    logic [`PPB_CFG_WORDS-1:0][31:0] mem;
    logic [31:0]                     rdata;
  } ppb_mem_st_t;

  ppb_mem_st_t r;
  ppb_mem_st_t next_r;

  assign rdata = r.rdata;

  always_comb begin
    next_r = r;
    next_r.rdata = r.mem[raddr];
    if (we) begin
      next_r.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // ppb_mem

// file: verif/ppb_bridge_chk.sv
// Port assertions for the pass-thru bridge
module ppb_bridge_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       pci_req,
  input wire logic [1:0] pci_region,
  input wire logic       pci_ack,
  input wire logic       addon_wr_n,
  input wire logic       passthru_done_n,
  input wire logic       passthru_attn_n,
  input wire logic       passthru_burst_n,
  input wire logic [1:0] passthru_region,
  input wire logic       pci_mail_event,
  input wire logic       buffered_bus_reset_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ack_pulse; pci_ack |=> !pci_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack too long");
  property p_ack_req; pci_ack |-> pci_req && $past(pci_req); endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
  property p_attn_ack; $rose(passthru_attn_n) |-> pci_ack; endproperty
  a_attn_ack: assert property (p_attn_ack)
    else $error("attention dropped without ack");
  property p_region;
    $fell(passthru_attn_n) |-> passthru_region == pci_region;
  endproperty
  a_region: assert property (p_region)
    else $error("wrong region");
  property p_done_ack;
    !passthru_attn_n && $fell(passthru_done_n) |=> pci_ack && passthru_attn_n;
  endproperty
  a_done_ack: assert property (p_done_ack)
    else $error("done not answered");
  property p_burst; !passthru_burst_n |-> !passthru_attn_n; endproperty
  a_burst: assert property (p_burst)
    else $error("burst outside transfer");
  property p_rst_out; $past(resetn) |-> buffered_bus_reset_n; endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("reset output stuck");
  property p_mail;
    $rose(pci_mail_event) |-> !$past(addon_wr_n) || !$past(addon_wr_n, 2);
  endproperty
  a_mail: assert property (p_mail)
    else $error("mail event without write");
  c_done: cover property ($fell(passthru_done_n));
  c_burst: cover property (!passthru_burst_n);
  c_mail: cover property ($rose(pci_mail_event));
endmodule // ppb_bridge_chk

bind ppb_bridge ppb_bridge_chk u_chk (.*);

// file: verif/ppb_glue_model.sv
// Glue responder that completes pass-thru words
module ppb_glue_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       passthru_attn_n,
  input  wire logic [7:0] hold,
  output logic            passthru_done_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      passthru_done_n <= 1'b1;
      cnt <= 8'h00;
    end else if (passthru_attn_n || !passthru_done_n) begin
      passthru_done_n <= 1'b1;
      cnt <= 8'h00;
    end else if (cnt == hold) begin
      passthru_done_n <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // ppb_glue_model

// file: verif/ppb_bridge_bench.sv
// Self-checking bench for the pass-thru bridge
module ppb_bridge_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ppb_pkg::*;
  logic clk, resetn, pci_req, pci_write, pci_burst, width_select;
  logic addon_select_n, addon_rd_n, addon_wr_n, passthru_addr_en_n;
  logic read_queue_strobe_n, write_queue_strobe_n, passthru_done_n;
  logic pci_ack, addon_data_oe, passthru_attn_n, passthru_burst_n;
  logic passthru_write, read_queue_empty, write_queue_full;
  logic pci_mail_event, addon_mail_event, buffered_bus_reset_n;
  logic rd_q = 1'b0, pend = 1'b0;
  ppb_space_t pci_space;
  logic [1:0] pci_region, passthru_region;
  logic [3:0] pci_lanes_n, lane_select_n, passthru_lanes_n;
  logic [4:0] addon_adr;
  logic [7:0] hold;
  logic [31:0] pci_addr, pci_wdata, pci_rdata, addon_data_in;
  logic [31:0] addon_data_out, lfsr_state, v, w[8], pq[$], aq[$];
  int miscompares, total_checks;
  ppb_bridge DUT (.*);
  ppb_glue_model glue (.*);
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h80200003)};
    return lfsr_state;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic pci(logic wr, ppb_space_t s, logic [31:0] a, d,
                     logic [1:0] r = 2'h0, logic b = 1'b0);
    if (!wr) pq.push_back(d);
    @(posedge clk);
    {pci_req, pci_write, pci_burst, pci_region} <= {1'b1, wr, b, r};
    pci_space <= s;
    {pci_addr, pci_wdata} <= {a, d};
    do @(posedge clk); while (pci_ack !== 1'b1);
    pci_req <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic ao(logic wr, logic [4:0] a, logic [31:0] d,
                    logic [3:0] l = 4'h0);
    if (!wr) aq.push_back(d);
    @(posedge clk);
    {addon_select_n, addon_wr_n, addon_rd_n} <= {1'b0, !wr, wr};
    {addon_adr, lane_select_n, addon_data_in} <= {a, l, d};
    repeat (2) @(posedge clk);
    {addon_select_n, addon_wr_n, addon_rd_n} <= 3'h7;
    @(posedge clk);
    #1;
  endtask
  task automatic qs(logic wr, logic [31:0] d);
    if (!wr) aq.push_back(d);
    @(posedge clk);
    {write_queue_strobe_n, read_queue_strobe_n} <= {!wr, wr};
    addon_data_in <= d;
    @(posedge clk);
    {write_queue_strobe_n, read_queue_strobe_n} <= 2'h3;
    @(posedge clk);
    #1;
  endtask
  task automatic pt(logic wr, logic [1:0] r, logic [31:0] d, logic [3:0] l);
    pci_lanes_n <= 4'(rnd());
    fork
      pci(wr, PPB_SP_PT, {22'h0, r, 8'h0}, d, r, wr);
      begin
        repeat (3) @(posedge clk);
        chk("ptwr", wr, passthru_write);
        chk("ptlanes", pci_lanes_n, passthru_lanes_n);
        ao(!wr, 5'h0b, l == 4'h0 ? d : {16'h0, d[15:0]}, l);
        if (l != 4'h0) ao(!wr, 5'h0b, {16'h0, d[31:16]}, ~l);
        if (wr) begin
          @(posedge clk);
          passthru_addr_en_n <= 1'b0;
          aq.push_back({22'h0, r, 8'h0});
          @(posedge clk);
          passthru_addr_en_n <= 1'b1;
        end
      end
    join
  endtask
  always @(posedge clk) begin
    if (pci_ack === 1'b1 && !pci_write) chk("rdata", pq.pop_front(), pci_rdata);
    if (pend) chk("aodata", aq.pop_front(), addon_data_out);
    if (pend) chk("aooe", 1'b1, addon_data_oe);
    pend <= (!addon_select_n && !addon_rd_n && !rd_q) ||
            !read_queue_strobe_n || !passthru_addr_en_n;
    rd_q <= !addon_select_n && !addon_rd_n;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200us;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {resetn, pci_req, pci_write, pci_burst, width_select} = '0;
    {addon_select_n, addon_rd_n, addon_wr_n, passthru_addr_en_n} = '1;
    {read_queue_strobe_n, write_queue_strobe_n} = 2'h3;
    {pci_region, pci_lanes_n, lane_select_n, addon_adr} = '0;
    {pci_addr, pci_wdata, addon_data_in} = '0;
    pci_space = PPB_SP_CFG;
    hold = 8'h1e;
    lfsr_state = 32'hf41af540;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("flags", 3'h5, {read_queue_empty, write_queue_full, buffered_bus_reset_n});
    pci(1'b1, PPB_SP_CFG, 32'h10, 32'h80000000);
    v = rnd();
    pci(1'b1, PPB_SP_CFG, 32'h8, v);
    pci(1'b0, PPB_SP_CFG, 32'h8, v);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      pci(1'b1, PPB_SP_OP, 32'(4 * i), v);
      chk("inmail", 1'b1, addon_mail_event);
      ao(1'b0, 5'(4 + i), v);
      v = rnd();
      ao(1'b1, 5'(i), v);
      chk("outmail", 1'b1, pci_mail_event);
      pci(1'b0, PPB_SP_OP, 32'(16 + 4 * i), v);
    end
    for (int i = 0; i < 8; i++) begin
      w[i] = rnd();
      pci(1'b1, PPB_SP_OP, 32'h20, w[i]);
    end
    pci(1'b0, PPB_SP_OP, 32'h34, 32'h00000c00);
    pci(1'b0, PPB_SP_OP, 32'h24, 32'h00000020);
    for (int i = 0; i < 8; i++) qs(1'b0, w[i]);
    chk("rqempty", 1'b1, read_queue_empty);
    for (int i = 0; i < 8; i++) qs(1'b1, w[i]);
    chk("wqfull", 1'b1, write_queue_full);
    pci(1'b0, PPB_SP_OP, 32'h20, w[0]);
    pt(1'b1, 2'h0, rnd(), 4'hc);
    pt(1'b0, 2'h0, rnd(), 4'hc);
    pt(1'b0, 2'h1, rnd(), 4'h0);
    pt(1'b1, 2'h1, rnd(), 4'h0);
    hold = 8'h01;
    pci(1'b1, PPB_SP_PT, 32'h300, rnd(), 2'h3);
    tally_and_finish();
  end
endmodule // ppb_bridge_bench
